// >>> src/copper_phy_status_irq_enable.v
// copper status register, interrupt enables and event flags behind an axi4-lite slave
`timescale 1ns/10ps
`include "copper_status_consts.vh"

module copper_phy_status_irq_enable (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [1:0]  phy_speed,
    input  wire        phy_duplex,
    input  wire        phy_aneg_complete,
    input  wire        phy_page_rx,
    input  wire        phy_link_rt,
    input  wire        phy_link_global,
    input  wire        phy_tx_pause,
    input  wire        phy_rx_pause,
    input  wire        phy_mdix_auto,
    input  wire        phy_downshift,
    input  wire        phy_energy_sleep,
    input  wire        phy_polarity_rev,
    input  wire        phy_jabber,
    input  wire        phy_ms_fault,
    input  wire        phy_pd_fault,
    input  wire        phy_no_hcd,
    input  wire        phy_symbol_err,
    input  wire        phy_false_carrier,
    output reg         irq
);

    // two-flop synchronisers for all phy-side levels
    localparam NIN = 19;
    wire [NIN-1:0] pin_raw = {phy_speed, phy_duplex, phy_aneg_complete, phy_page_rx,
                              phy_link_rt, phy_link_global, phy_tx_pause, phy_rx_pause,
                              phy_mdix_auto, phy_downshift, phy_energy_sleep,
                              phy_polarity_rev, phy_jabber, phy_ms_fault, phy_pd_fault,
                              phy_no_hcd, phy_symbol_err, phy_false_carrier};
    reg  [NIN-1:0] sync1_reg;
    reg  [NIN-1:0] sync2_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= {NIN{1'b0}};
            sync2_reg <= {NIN{1'b0}};
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end
    wire [1:0] s_speed      = sync2_reg[18:17];
    wire       s_duplex     = sync2_reg[16];
    wire       s_aneg_done  = sync2_reg[15];
    wire       s_page_rx    = sync2_reg[14];
    wire       s_link_rt    = sync2_reg[13];
    wire       s_link_glb   = sync2_reg[12];
    wire       s_tx_pause   = sync2_reg[11];
    wire       s_rx_pause   = sync2_reg[10];
    wire       s_mdix_auto  = sync2_reg[9];
    wire       s_downshift  = sync2_reg[8];
    wire       s_energy     = sync2_reg[7];
    wire       s_pol_rev    = sync2_reg[6];
    wire       s_jabber     = sync2_reg[5];
    wire       s_ms_fault   = sync2_reg[4];
    wire       s_pd_fault   = sync2_reg[3];
    wire       s_no_hcd     = sync2_reg[2];
    wire       s_sym_err    = sync2_reg[1];
    wire       s_false_car  = sync2_reg[0];

    // control register: aneg enable, polarity disable, soft reset, crossover mode
    reg  [5:0]  ctrl_reg;
    reg  [1:0]  xover_active_reg;
    reg         soft_rst_reg;
    reg  [15:0] status_reg;
    reg  [15:0] irq_en_reg;
    reg  [15:0] evt_stat_reg;
    reg  [15:0] evt_mask_reg;
    reg  [15:0] prev_reg;
    reg         page_latch_reg;

    wire aneg_en  = ctrl_reg[`CTRL_ANEG_EN];
    wire resolved = aneg_en ? s_aneg_done : 1'b1;
    wire manual   = (xover_active_reg == `XOVER_MANUAL_MDI) ||
                    (xover_active_reg == `XOVER_MANUAL_MDIX);
    wire mdix_now = manual ? xover_active_reg[0] : s_mdix_auto;
    wire pol_now  = s_pol_rev & ~ctrl_reg[`CTRL_POL_DIS];

    // write channel: address and data taken in any order, answer after both
    reg  [7:0]  waddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    reg         aw_have_reg;
    reg         w_have_reg;
    wire        aw_take = s_axi_awvalid & s_axi_awready;
    wire        w_take  = s_axi_wvalid & s_axi_wready;
    wire        wr_go   = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire        rd_take = s_axi_arvalid & s_axi_arready;

    // byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16 = old;
            if (strb[0])
                merge16[7:0] = data[7:0];
            if (strb[1])
                merge16[15:8] = data[15:8];
        end
    endfunction

    wire wr_en_hit  = wr_go & (waddr_reg == `REG_ADDR_IRQ_EN);
    wire wr_st_hit  = wr_go & (waddr_reg == `REG_ADDR_EVT_STAT);
    wire wr_mk_hit  = wr_go & (waddr_reg == `REG_ADDR_EVT_MASK);
    wire wr_ct_hit  = wr_go & (waddr_reg == `REG_ADDR_CTRL);
    wire rd_st_hit  = rd_take & (s_axi_araddr == `REG_ADDR_STATUS);
    wire wr_mapped  = (waddr_reg == `REG_ADDR_STATUS) | (waddr_reg == `REG_ADDR_IRQ_EN) |
                      (waddr_reg == `REG_ADDR_EVT_STAT) | (waddr_reg == `REG_ADDR_EVT_MASK) |
                      (waddr_reg == `REG_ADDR_CTRL);

    // event sources
    wire aneg_err = s_ms_fault | s_pd_fault | s_no_hcd |
                    (resolved & aneg_en & ~s_link_glb);
    reg  [15:0] evt_now;
    always @* begin
        evt_now = 16'h0000;
        evt_now[`EVT_ANEG_ERR]      = aneg_err & ~prev_reg[`EVT_ANEG_ERR];
        evt_now[`EVT_SPEED_CHG]     = resolved & (s_speed != status_reg[15:14]);
        evt_now[`EVT_DUPLEX_CHG]    = resolved & (s_duplex != status_reg[`ST_DUPLEX]);
        evt_now[`EVT_PAGE_RX]       = s_page_rx & ~prev_reg[`EVT_PAGE_RX];
        evt_now[`EVT_ANEG_DONE]     = s_aneg_done & ~prev_reg[`EVT_ANEG_DONE];
        evt_now[`EVT_LINK_CHG]      = s_link_rt != status_reg[`ST_LINK_RT];
        evt_now[`EVT_SYMBOL_ERR]    = s_sym_err & ~prev_reg[`EVT_SYMBOL_ERR];
        evt_now[`EVT_FALSE_CARRIER] = s_false_car & ~prev_reg[`EVT_FALSE_CARRIER];
        evt_now[`EVT_XOVER_CHG]     = mdix_now != status_reg[`ST_MDIX];
        evt_now[`EVT_DOWNSHIFT]     = s_downshift & ~status_reg[`ST_DOWNSHIFT];
        evt_now[`EVT_ENERGY_CHG]    = s_energy != status_reg[`ST_ENERGY];
        evt_now[`EVT_FLP_NO_LINK]   = s_aneg_done & ~s_link_glb & ~prev_reg[`EVT_FLP_NO_LINK];
        evt_now[`EVT_POL_CHG]       = pol_now != status_reg[`ST_POLARITY];
        evt_now[`EVT_JABBER]        = s_jabber & ~status_reg[`ST_JABBER];
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= 16'h0000;
        end else begin
            prev_reg[`EVT_ANEG_ERR]      <= aneg_err;
            prev_reg[`EVT_PAGE_RX]       <= s_page_rx;
            prev_reg[`EVT_ANEG_DONE]     <= s_aneg_done;
            prev_reg[`EVT_SYMBOL_ERR]    <= s_sym_err;
            prev_reg[`EVT_FALSE_CARRIER] <= s_false_car;
            prev_reg[`EVT_FLP_NO_LINK]   <= s_aneg_done & ~s_link_glb;
        end
    end

    // status snapshot; speed, duplex and crossover keep their value across soft reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            status_reg                 <= 16'h0000;
            status_reg[15:14]          <= `SPEED_RESET;
            status_reg[`ST_MDIX]       <= `MDIX_RESET;
            page_latch_reg             <= 1'b0;
        end else if (soft_rst_reg) begin
            status_reg[12:7]           <= 6'h00;
            status_reg[5:0]            <= 6'h00;
            page_latch_reg             <= 1'b0;
        end else begin
            status_reg[15:14]          <= s_speed;
            status_reg[`ST_DUPLEX]     <= s_duplex;
            status_reg[`ST_RESOLVED]   <= resolved;
            status_reg[`ST_LINK_RT]    <= s_link_rt;
            status_reg[`ST_TX_PAUSE]   <= s_tx_pause;
            status_reg[`ST_RX_PAUSE]   <= s_rx_pause;
            status_reg[`ST_MDIX]       <= mdix_now;
            status_reg[`ST_DOWNSHIFT]  <= s_downshift;
            status_reg[`ST_ENERGY]     <= s_energy;
            status_reg[`ST_LINK_GLOBAL] <= s_link_glb;
            status_reg[`ST_POLARITY]   <= pol_now;
            status_reg[`ST_JABBER]     <= s_jabber;
            // a new page wins over the clear of the read that returns it
            if (evt_now[`EVT_PAGE_RX])
                page_latch_reg <= 1'b1;
            else if (rd_st_hit)
                page_latch_reg <= 1'b0;
        end
    end

    // registers written by software
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_reg       <= `IRQ_EN_RESET;
            evt_stat_reg     <= 16'h0000;
            evt_mask_reg     <= 16'h0000;
            ctrl_reg         <= 6'h31;
            xover_active_reg <= 2'h3;
            soft_rst_reg     <= 1'b0;
            irq              <= 1'b0;
        end else begin
            soft_rst_reg <= wr_ct_hit & wstrb_reg[0] & wdata_reg[`CTRL_SW_RESET];
            if (soft_rst_reg)
                xover_active_reg <= ctrl_reg[`CTRL_XOVER_HI:`CTRL_XOVER_LO];
            // reserved bits 7 and 2 stay zero whatever software writes
            if (wr_en_hit)
                irq_en_reg <= merge16(irq_en_reg, wdata_reg, wstrb_reg) &
                              `IRQ_EN_WMASK;
            if (wr_mk_hit)
                evt_mask_reg <= merge16(evt_mask_reg, wdata_reg, wstrb_reg) &
                                `IRQ_EN_WMASK;
            if (wr_ct_hit && wstrb_reg[0])
                ctrl_reg <= {wdata_reg[5:4], 1'b0, 1'b0, wdata_reg[1:0]};
            // write-one-to-clear; a new event in the same cycle wins
            if (soft_rst_reg)
                evt_stat_reg <= 16'h0000;
            else if (wr_st_hit)
                evt_stat_reg <= (evt_stat_reg &
                                 ~merge16(16'h0000, wdata_reg, wstrb_reg)) |
                                (evt_now & `IRQ_EN_WMASK);
            else
                evt_stat_reg <= evt_stat_reg | (evt_now & `IRQ_EN_WMASK);
            irq <= |(evt_stat_reg & irq_en_reg & ~evt_mask_reg);
        end
    end

    // axi4-lite write path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            waddr_reg     <= 8'h00;
            wdata_reg     <= 32'h00000000;
            wstrb_reg     <= 4'h0;
        end else begin
            if (aw_take) begin
                waddr_reg     <= s_axi_awaddr;
                aw_have_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                w_have_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // axi4-lite read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `AXI_RESP_OKAY;
                case (s_axi_araddr)
                    `REG_ADDR_STATUS:
                        s_axi_rdata <= {16'h0000, status_reg[15:13], page_latch_reg,
                                        status_reg[11:0]};
                    `REG_ADDR_IRQ_EN:   s_axi_rdata <= {16'h0000, irq_en_reg};
                    `REG_ADDR_EVT_STAT: s_axi_rdata <= {16'h0000, evt_stat_reg};
                    `REG_ADDR_EVT_MASK: s_axi_rdata <= {16'h0000, evt_mask_reg};
                    `REG_ADDR_CTRL:     s_axi_rdata <= {26'h0000000, ctrl_reg};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `AXI_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // copper_phy_status_irq_enable

// >>> src/copper_status_consts.vh
// register offsets, field positions and reset values for the copper status block
`ifndef COPPER_STATUS_CONSTS_VH
`define COPPER_STATUS_CONSTS_VH

`define REG_IDX_STATUS      8'h11
`define REG_IDX_IRQ_EN      8'h12
`define REG_ADDR_STATUS     8'h44
`define REG_ADDR_IRQ_EN     8'h48
`define REG_ADDR_EVT_STAT   8'h80
`define REG_ADDR_EVT_MASK   8'h84
`define REG_ADDR_CTRL       8'h88

`define ST_SPEED_HI         15
`define ST_SPEED_LO         14
`define ST_DUPLEX           13
`define ST_PAGE_RX          12
`define ST_RESOLVED         11
`define ST_LINK_RT          10
`define ST_TX_PAUSE         9
`define ST_RX_PAUSE         8
`define ST_MDIX             6
`define ST_DOWNSHIFT        5
`define ST_ENERGY           4
`define ST_LINK_GLOBAL      3
`define ST_POLARITY         1
`define ST_JABBER           0

`define SPEED_RESET         2'h2
`define MDIX_RESET          1'h1
`define IRQ_EN_RESET        16'h0000
`define IRQ_EN_WMASK        16'hFF7B

`define CTRL_ANEG_EN        0
`define CTRL_POL_DIS        1
`define CTRL_SW_RESET       2
`define CTRL_XOVER_LO       4
`define CTRL_XOVER_HI       5
`define XOVER_MANUAL_MDI    2'h0
`define XOVER_MANUAL_MDIX   2'h1

`define EVT_ANEG_ERR        15
`define EVT_SPEED_CHG       14
`define EVT_DUPLEX_CHG      13
`define EVT_PAGE_RX         12
`define EVT_ANEG_DONE       11
`define EVT_LINK_CHG        10
`define EVT_SYMBOL_ERR      9
`define EVT_FALSE_CARRIER   8
`define EVT_XOVER_CHG       6
`define EVT_DOWNSHIFT       5
`define EVT_ENERGY_CHG      4
`define EVT_FLP_NO_LINK     3
`define EVT_POL_CHG         1
`define EVT_JABBER          0

`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// >>> test/copper_phy_status_irq_enable_chk.sv
// bus and register-read assertions for the copper status block
`timescale 1ns/10ps
module copper_phy_status_irq_enable_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_answer: assert property (s_ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("read data upper half not zero");
    a_rsv_enable: assert property (s_ar_take ##0 (s_axi_araddr == 8'h48)
        |=> s_axi_rdata[7] == 1'h0 && s_axi_rdata[2] == 1'h0) else $error("reserved enable bit set");
    a_unmapped_err: assert property (s_ar_take ##0 (s_axi_araddr == 8'h40)
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // the answer needs one cycle to register the taken pair, then bvalid rises
    a_write_answer: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready
        ##1 s_axi_bvalid) else $error("write answer missing");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##0 s_axi_awready)
        else $error("write channel not freed");
    a_status_wr_ok: assert property (s_wr_take ##0 (s_axi_awaddr == 8'h44)
        |=> ##1 s_axi_bresp == 2'h0) else $error("status write not answered okay");
endmodule // copper_phy_status_irq_enable_chk

bind copper_phy_status_irq_enable copper_phy_status_irq_enable_chk i_chk (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// >>> test/tb_copper_phy_status_irq_enable.sv
// self-checking bench for the copper status and interrupt enable block
`timescale 1ns/10ps
module tb_copper_phy_status_irq_enable;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic [18:0] p = 19'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata;
    int          n_mismatch = 0, num_checks = 0;
    int          causes[4] = '{14, 15, 16, 3};

    copper_phy_status_irq_enable i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .phy_speed(p[1:0]), .phy_duplex(p[2]), .phy_aneg_complete(p[3]), .phy_page_rx(p[4]),
        .phy_link_rt(p[5]), .phy_link_global(p[6]), .phy_tx_pause(p[7]), .phy_rx_pause(p[8]),
        .phy_mdix_auto(p[9]), .phy_downshift(p[10]), .phy_energy_sleep(p[11]),
        .phy_polarity_rev(p[12]), .phy_jabber(p[13]), .phy_ms_fault(p[14]), .phy_pd_fault(p[15]),
        .phy_no_hcd(p[16]), .phy_symbol_err(p[17]), .phy_false_carrier(p[18]), .irq(irq));

    always #10 aclk = ~aclk;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'h0;
    endtask

    // read, mask, compare; response must be okay unless unmapped
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string nm);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        chk(nm, rdata & m, e);
        chk("read response", {30'h0, rresp}, (a == 8'h40) ? 32'h2 : 32'h0);
    endtask

    function automatic logic [31:0] st_exp(input logic [18:0] q);
        return {16'h0, q[1:0], q[2], 1'h0, q[3], q[5], q[7], q[8], 1'h0, q[9], q[10], q[11],
                q[6], 1'h0, q[12], q[13]};
    endfunction

    task automatic t_status;
        logic [13:0] pats[3] = '{14'h0008, 14'h3FED, 14'h2A4A};
        rd_chk(8'h48, 32'hFFFF, 32'h0, "enable after reset");
        rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped read");
        foreach (pats[i]) begin
            p <= {5'h0, pats[i]};
            repeat (4) @(posedge aclk);
            rd_chk(8'h44, 32'hFFFFFFFF, st_exp({5'h0, pats[i]}), "status");
        end
        wr(8'h44, 32'h0000FFFF);
        chk("status write resp", {30'h0, r}, 32'h0);
        rd_chk(8'h44, 32'hFFFF, st_exp({5'h0, pats[2]}), "status after write");
    endtask

    task automatic t_page_pol;
        p <= 19'h01018;
        repeat (3) @(posedge aclk);
        p <= 19'h01008;
        repeat (4) @(posedge aclk);
        rd_chk(8'h44, 32'h1002, 32'h1002, "page latched");
        rd_chk(8'h44, 32'h1000, 32'h0, "page cleared by read");
        wr(8'h88, 32'h33);
        repeat (4) @(posedge aclk);
        rd_chk(8'h44, 32'h2, 32'h0, "polarity forced normal");
        wr(8'h88, 32'h31);
    endtask

    task automatic t_soft_reset;
        wr(8'h48, 32'hFF7B);
        rd_chk(8'h48, 32'hFFFF, 32'hFF7B, "enable write");
        p <= 19'h0;
        wr(8'h88, 32'h10);
        repeat (4) @(posedge aclk);
        rd_chk(8'h44, 32'h0840, 32'h0800, "mode before soft reset");
        p <= 19'h00010;
        repeat (3) @(posedge aclk);
        p <= 19'h0;
        wr(8'h88, 32'h14);
        repeat (4) @(posedge aclk);
        rd_chk(8'h44, 32'h1840, 32'h0840, "soft reset mdix");
        rd_chk(8'h48, 32'hFFFF, 32'hFF7B, "enable kept");
        // only the low byte lane is written
        wstrb <= 4'h1;
        wr(8'h48, 32'h0);
        wstrb <= 4'hF;
        rd_chk(8'h48, 32'hFFFF, 32'hFF00, "enable low lane");
        p <= 19'h00200;
        wr(8'h88, 32'h0);
        wr(8'h88, 32'h4);
        repeat (4) @(posedge aclk);
        rd_chk(8'h44, 32'h0040, 32'h0, "manual mdi");
        wr(8'h88, 32'h35);
        repeat (4) @(posedge aclk);
        rd_chk(8'h44, 32'h0040, 32'h0040, "auto crossover");
    endtask

    // event input is lowered before its clear, since a live event beats the clear
    task automatic t_irq;
        wr(8'h48, 32'h8001);
        p <= 19'h0;
        repeat (5) @(posedge aclk);
        wr(8'h80, 32'hFFFF);
        repeat (2) @(posedge aclk);
        chk("irq idle", {31'h0, irq}, 32'h0);
        p[13] <= 1'h1;
        repeat (5) @(posedge aclk);
        chk("irq jabber", {31'h0, irq}, 32'h1);
        rd_chk(8'h80, 32'h1, 32'h1, "jabber event");
        p[13] <= 1'h0;
        wr(8'h84, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(8'h84, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(8'h80, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        foreach (causes[i]) begin
            p[causes[i]] <= 1'h1;
            repeat (5) @(posedge aclk);
            rd_chk(8'h80, 32'h8000, 32'h8000, "negotiation error");
            chk("irq negotiation error", {31'h0, irq}, 32'h1);
            p[causes[i]] <= 1'h0;
            repeat (4) @(posedge aclk);
            wr(8'h80, 32'hFFFF);
        end
    endtask

    task automatic t_hard_reset;
        p <= 19'h00212;
        repeat (4) @(posedge aclk);
        p <= 19'h00202;
        aresetn <= 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        chk("irq after reset", {31'h0, irq}, 32'h0);
        rd_chk(8'h48, 32'hFFFF, 32'h0, "enable hard reset");
        rd_chk(8'h44, 32'hD040, 32'h8040, "status hard reset");
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        t_status;
        t_page_pol;
        t_soft_reset;
        t_irq;
        t_hard_reset;
        give_verdict;
    end

    // the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        give_verdict;
    end
endmodule // tb_copper_phy_status_irq_enable
